// File: core/rxfs_params.svh
// Constants for the receive client frame-check and status block
`ifndef RXFS_PARAMS_SVH
`define RXFS_PARAMS_SVH

`define RXFS_DATA_W 256
`define RXFS_LANES 32
`define RXFS_EMPTY_W 5
`define RXFS_ERR_W 6
`define RXFS_KIND_W 3
`define RXFS_LEN_W 16

// Control frame recognition, offsets counted from the MSB lane
`define RXFS_TYPE_HI 159
`define RXFS_OPC_HI 143
`define RXFS_ETYPE_CTRL 16'h8808
`define RXFS_OPC_PAUSE 16'h0001
`define RXFS_OPC_PFC 16'h0101

// Kind bit positions
`define RXFS_KIND_STD 0
`define RXFS_KIND_PFC 1
`define RXFS_KIND_OTHER 2

// Error vector bit positions
`define RXFS_ERR_MALFORM 0
`define RXFS_ERR_CRC 1
`define RXFS_ERR_UNDER 2
`define RXFS_ERR_OVER 3
`define RXFS_ERR_LENGTH 4

// Runt window in bytes; eight or fewer is a decode error instead
`define RXFS_RUNT_MIN 16'h0009
`define RXFS_RUNT_MAX 16'h003F
`define RXFS_LEN_MAX 16'hFFFF

// Reset values
`define RXFS_KIND_RST 3'h0
`define RXFS_ERR_RST 6'h00

`endif

// File: core/rxfs_pkg.sv
// Types for the receive client frame-check and status block
`include "rxfs_params.svh"

package rxfs_pkg;

    // One beat from the receive MAC pipeline, byte 0 in the LSB lane
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic crcBad;
        logic [`RXFS_ERR_W-1:0] err;
        logic [`RXFS_EMPTY_W-1:0] empty;
        logic [`RXFS_DATA_W-1:0] data;
    } rxfs_beat_t;

    typedef enum logic [1:0] {
        RXFS_IDLE = 2'h0,
        RXFS_BODY = 2'h1
    } rxfs_state_t;

endpackage : rxfs_pkg

// File: core/rxfs_ctrl_class.sv
// Classifies the control frame kind from a packet's first beat
`timescale 1ns/1ps
`default_nettype none
`include "rxfs_params.svh"

module rxfs_ctrl_class
    import rxfs_pkg::*;
(
    input wire logic [`RXFS_DATA_W-1:0] firstData,
    input wire logic pfcMode,
    input wire logic fwdCtrl,
    output logic [`RXFS_KIND_W-1:0] kind
);

    logic [15:0] etherType;
    logic [15:0] opcode;
    logic isCtrl;

    assign etherType = firstData[`RXFS_TYPE_HI -: 16];
    assign opcode = firstData[`RXFS_OPC_HI -: 16];
    assign isCtrl = (etherType == `RXFS_ETYPE_CTRL);

    always_comb begin
        kind = `RXFS_KIND_RST;
        if (isCtrl) begin
            if (opcode == `RXFS_OPC_PAUSE) begin
                // Pause frames consumed in standard mode stay unreported
                kind[`RXFS_KIND_STD] = pfcMode | fwdCtrl;
            end else if (opcode == `RXFS_OPC_PFC) begin
                kind[`RXFS_KIND_PFC] = ~pfcMode | fwdCtrl;
            end else begin
                kind[`RXFS_KIND_OTHER] = 1'b1;
            end
        end
    end

endmodule : rxfs_ctrl_class
`default_nettype wire

// File: core/rxfs_status.sv
// Receive client valid qualifier, frame-check pair and control status
//
// Notes on behaviour
// - All outputs registered on the receive clock
// - First packet byte sits in MSB lane
// - Valid only from first through last beat
// - Frame-check valid marks the result's cycle
// - Frame-check error only with frame-check valid
// - Runt frames always force frame-check error
// - Eight bytes or fewer are not runts
// - Control kind meaningful only on last beat
// - Bit 0: pause frame, masked in standard mode unless forwarded
// - Bit 1: priority pause, masked in PFC mode unless forwarded
// - Bit 2: other control frame
// - Error vector CRC bit equals frame-check error
`timescale 1ns/1ps
`default_nettype none
`include "rxfs_params.svh"

module rxfs_status
    import rxfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic fwdCtrl,
    input wire logic pfcMode,
    input wire rxfs_beat_t upBeat,
    output logic rxBeatValid,
    output logic rxPacketFirstBeat,
    output logic rxPacketLastBeat,
    output logic [`RXFS_DATA_W-1:0] rxData,
    output logic [`RXFS_EMPTY_W-1:0] rxEmpty,
    output logic rxFrameCheckValid,
    output logic rxFrameCheckError,
    output logic [`RXFS_KIND_W-1:0] rxControlFrameKind,
    output logic [`RXFS_ERR_W-1:0] rxErrorVector
);

    // Reverse byte order so byte 0 of the packet lands in the MSB lane
    function automatic logic [`RXFS_DATA_W-1:0] msbFirst(
        input logic [`RXFS_DATA_W-1:0] d
    );
        logic [`RXFS_DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < `RXFS_LANES; i++) begin
            r[`RXFS_DATA_W-1-8*i -: 8] = d[8*i +: 8];
        end
        return r;
    endfunction : msbFirst

    // Saturating length add, so jumbo streams never wrap into the runt window
    function automatic logic [`RXFS_LEN_W-1:0] addSat(
        input logic [`RXFS_LEN_W-1:0] a,
        input logic [`RXFS_LEN_W-1:0] b
    );
        logic [`RXFS_LEN_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s[`RXFS_LEN_W]) begin
            return `RXFS_LEN_MAX;
        end
        return s[`RXFS_LEN_W-1:0];
    endfunction : addSat

    rxfs_state_t state;
    rxfs_state_t next_state;
    logic accept;
    logic [`RXFS_DATA_W-1:0] alignedData;
    logic [`RXFS_KIND_W-1:0] classNow;
    logic [`RXFS_KIND_W-1:0] kindHeld;
    logic [`RXFS_KIND_W-1:0] kindNow;
    logic [`RXFS_LEN_W-1:0] byteCount;
    logic [`RXFS_LEN_W-1:0] beatBytes;
    logic [`RXFS_LEN_W-1:0] next_byteCount;
    logic isRunt;
    logic checkErr;
    logic firstTaken;
    logic lastTaken;
    logic [`RXFS_LEN_W-1:0] baseCount;
    logic overDecode;
    logic underMin;

    assign alignedData = msbFirst(upBeat.data);

    // Beats outside a packet are dropped rather than passed as stray data
    assign accept = upBeat.valid &&
                    (upBeat.first || state == RXFS_BODY);

    // The two strobes that the kind, first/last, check and error registers below key on
    assign firstTaken = accept && upBeat.first;
    assign lastTaken = accept && upBeat.last;

    always_comb begin
        next_state = state;
        case (state)
            RXFS_IDLE: begin
                if (accept && !upBeat.last) begin
                    next_state = RXFS_BODY;
                end
            end
            RXFS_BODY: begin
                if (accept && upBeat.last) begin
                    next_state = RXFS_IDLE;
                end
            end
            default: begin
                next_state = RXFS_IDLE;
            end
        endcase
    end

    // clkEn low holds every register here, so a shown pulse stays shown
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= RXFS_IDLE;
        end else if (clkEn) begin
            state <= next_state;
        end
    end

    // A first beat restarts the count, even inside an unfinished packet
    assign baseCount = upBeat.first ? '0 : byteCount;

    // Byte length of the packet so far, including this beat
    always_comb begin
        beatBytes = `RXFS_LEN_W'(`RXFS_LANES);
        if (upBeat.last) begin
            beatBytes = `RXFS_LEN_W'(`RXFS_LANES) -
                        `RXFS_LEN_W'(upBeat.empty);
        end
        next_byteCount = addSat(baseCount, beatBytes);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            byteCount <= '0;
        end else if (clkEn && accept) begin
            byteCount <= next_byteCount;
        end
    end

    // Packets of eight bytes or fewer fall below the window: decode error
    assign overDecode = next_byteCount >= `RXFS_RUNT_MIN;
    assign underMin = next_byteCount <= `RXFS_RUNT_MAX;
    assign isRunt = overDecode && underMin;
    assign checkErr = upBeat.crcBad || isRunt;

    rxfs_ctrl_class u_class (
        .firstData(alignedData),
        .pfcMode(pfcMode),
        .fwdCtrl(fwdCtrl),
        .kind(classNow)
    );

    // Kind is decided on the first beat and held until the last
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            kindHeld <= `RXFS_KIND_RST;
        end else if (clkEn && firstTaken) begin
            kindHeld <= classNow;
        end
    end

    // A one-beat packet has no held kind yet, so it is taken directly
    assign kindNow = upBeat.first ? classNow : kindHeld;

    // Stream qualifiers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxBeatValid <= 1'b0;
            rxPacketFirstBeat <= 1'b0;
            rxPacketLastBeat <= 1'b0;
        end else if (clkEn) begin
            rxBeatValid <= accept;
            rxPacketFirstBeat <= firstTaken;
            rxPacketLastBeat <= lastTaken;
        end
    end

    // Data lanes are not reset; they mean nothing while valid is low
    always_ff @(posedge ref_clk) begin
        if (clkEn && accept) begin
            rxData <= alignedData;
            rxEmpty <= upBeat.last ? upBeat.empty : '0;
        end
    end

    // Check result and status appear only with the last beat
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxFrameCheckValid <= 1'b0;
            rxFrameCheckError <= 1'b0;
            rxControlFrameKind <= `RXFS_KIND_RST;
        end else if (clkEn) begin
            rxFrameCheckValid <= lastTaken;
            rxFrameCheckError <= lastTaken && checkErr;
            // Zero between ends, so a careless sink reads no stale kind
            rxControlFrameKind <= lastTaken ? kindNow : `RXFS_KIND_RST;
        end
    end

    // Error vector: runt and CRC bits are made here, malformed, over and length forwarded
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxErrorVector <= `RXFS_ERR_RST;
        end else if (clkEn) begin
            rxErrorVector <= `RXFS_ERR_RST;
            if (lastTaken) begin
                rxErrorVector[`RXFS_ERR_MALFORM] <=
                    upBeat.err[`RXFS_ERR_MALFORM];
                rxErrorVector[`RXFS_ERR_CRC] <= checkErr;
                rxErrorVector[`RXFS_ERR_UNDER] <= isRunt;
                rxErrorVector[`RXFS_ERR_OVER] <= upBeat.err[`RXFS_ERR_OVER];
                rxErrorVector[`RXFS_ERR_LENGTH] <=
                    upBeat.err[`RXFS_ERR_LENGTH];
            end
        end
    end

endmodule : rxfs_status
`default_nettype wire

// File: tb/rxfs_status_asserts.sv
// Assertion checker for the receive status block
`timescale 1ns/1ps
`default_nettype none
`include "rxfs_params.svh"
module rxfs_status_chk
    import rxfs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic fwdCtrl,
    input wire logic pfcMode,
    input wire rxfs_beat_t upBeat,
    input wire logic rxBeatValid,
    input wire logic rxPacketFirstBeat,
    input wire logic rxPacketLastBeat,
    input wire logic [`RXFS_DATA_W-1:0] rxData,
    input wire logic rxFrameCheckValid,
    input wire logic rxFrameCheckError,
    input wire logic [`RXFS_KIND_W-1:0] rxControlFrameKind,
    input wire logic [`RXFS_ERR_W-1:0] rxErrorVector
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_err_needs_valid:
    assert property (rxFrameCheckError |-> rxFrameCheckValid)
        else $error("check error without check valid");
    a_check_on_last:
    assert property (rxBeatValid && rxPacketLastBeat |-> rxFrameCheckValid)
        else $error("check valid missing");
    a_kind_on_last:
    assert property (|rxControlFrameKind |-> rxPacketLastBeat)
        else $error("kind off last beat");
    a_crc_bit_same:
    assert property (rxErrorVector[`RXFS_ERR_CRC] == rxFrameCheckError)
        else $error("error vector crc bit differs");
    a_runt_errors:
    assert property (rxErrorVector[`RXFS_ERR_UNDER] |-> rxFrameCheckError)
        else $error("runt without check error");
    a_first_beat_lat:
    assert property (clkEn && upBeat.valid && upBeat.first
        |=> rxBeatValid && rxPacketFirstBeat
        && rxData[255:248] == $past(upBeat.data[7:0]))
        else $error("first beat not shown");
    a_idle_quiet:
    assert property (clkEn && !upBeat.valid |=> !rxBeatValid)
        else $error("valid outside packet");
    a_pause_mask:
    assert property ($past(clkEn) && !$past(pfcMode) && !$past(fwdCtrl)
        |-> !rxControlFrameKind[0]) else $error("pause not masked");
    a_pfc_mask:
    assert property ($past(clkEn) && $past(pfcMode) && !$past(fwdCtrl)
        |-> !rxControlFrameKind[1]) else $error("priority not masked");
endmodule : rxfs_status_chk
bind rxfs_status rxfs_status_chk u_chk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .fwdCtrl(fwdCtrl),
    .pfcMode(pfcMode),
    .upBeat(upBeat),
    .rxBeatValid(rxBeatValid),
    .rxPacketFirstBeat(rxPacketFirstBeat),
    .rxPacketLastBeat(rxPacketLastBeat),
    .rxData(rxData),
    .rxFrameCheckValid(rxFrameCheckValid),
    .rxFrameCheckError(rxFrameCheckError),
    .rxControlFrameKind(rxControlFrameKind),
    .rxErrorVector(rxErrorVector)
);
`default_nettype wire

// File: tb/rxfs_sink.sv
// Client sink model: keeps the kind of each finished packet
`timescale 1ns/1ps
`default_nettype none
module rxfs_sink (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rxBeatValid,
    input wire logic rxPacketLastBeat,
    input wire logic [2:0] rxControlFrameKind,
    output logic [2:0] lastKind
);
    // Kind is ignored on any other beat, where it carries no meaning
    // Taking it at the last beat relies on status aligned to that beat
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lastKind <= 3'h0;
        end else if (rxBeatValid && rxPacketLastBeat) begin
            lastKind <= rxControlFrameKind;
        end
    end
endmodule : rxfs_sink
`default_nettype wire

// File: tb/rxfs_status_tb.sv
// Testbench for the receive status block
`timescale 1ns/1ps
`default_nettype none
module rxfs_status_tb
    import rxfs_pkg::*;
;
    logic ref_clk = 0, rst_n = 0, fwdCtrl = 0, pfcMode = 0, clkEn = 1;
    rxfs_beat_t upBeat = '0;
    logic bv, fb, lb, fcv, fce;
    logic [255:0] rxData;
    logic [2:0] kind, lastKind;
    logic [5:0] ev;
    logic [4:0] emp;
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    rxfs_status dut (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
        .fwdCtrl(fwdCtrl), .pfcMode(pfcMode), .upBeat(upBeat),
        .rxBeatValid(bv), .rxPacketFirstBeat(fb), .rxPacketLastBeat(lb),
        .rxData(rxData), .rxEmpty(emp), .rxFrameCheckValid(fcv),
        .rxFrameCheckError(fce), .rxControlFrameKind(kind),
        .rxErrorVector(ev));
    rxfs_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .rxBeatValid(bv),
        .rxPacketLastBeat(lb), .rxControlFrameKind(kind), .lastKind(lastKind));
    initial forever #10 ref_clk = ~ref_clk;
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Ethertype and opcode bytes 12..15, byte 0 marked for the lane check
    function automatic logic [255:0] mk(input logic [15:0] opc);
        mk = '0;
        mk[7:0] = 8'hA5;
        mk[111:96] = 16'h0888;
        mk[127:112] = {opc[7:0], opc[15:8]};
    endfunction : mk
    // Beats go back to back; returns once the last beat's outputs settle
    task pkt(input logic [255:0] d, input int n, input logic [4:0] e,
        input logic c);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            upBeat <= '{1'b1, i == 0, i == n - 1, c, 6'h00,
                (i == n - 1) ? e : 5'h00, d};
        end
        @(posedge ref_clk);
        upBeat.valid <= 1'b0;
        #1;
    endtask : pkt
    task t_stray;
        @(posedge ref_clk);
        upBeat <= '{1'b1, 1'b0, 1'b0, 1'b0, 6'h00, 5'h00, 256'h1};
        @(posedge ref_clk);
        upBeat.valid <= 1'b0;
        #1;
        chk({7'h00, bv}, 8'h00);
    endtask : t_stray
    task t_kinds;
        logic [15:0] opc [3] = '{16'h0001, 16'h0101, 16'h0002};
        logic [2:0] x;
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 3; k++) begin
                @(posedge ref_clk);
                pfcMode <= m[1];
                fwdCtrl <= m[0];
                pkt(mk(opc[k]), 2, 5'h00, 1'b0);
                x = 3'h1 << k;
                if (k == 0 && m == 0) x = 3'h0;
                if (k == 1 && m == 2) x = 3'h0;
                chk({6'h00, fcv, fce}, 8'h02);
                chk({5'h00, kind}, {5'h00, x});
                // The sink takes the kind one edge after it is shown
                @(posedge ref_clk);
                #1;
                chk({5'h00, lastKind}, {5'h00, x});
            end
        end
    endtask : t_kinds
    task t_runt;
        int nb [6] = '{1, 2, 2, 1, 1, 3};
        logic [4:0] em [6] = '{5'h17, 5'h01, 5'h00, 5'h18, 5'h18, 5'h00};
        logic [7:0] ex [6] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h02, 8'h02};
        for (int i = 0; i < 6; i++) begin
            pkt(256'h5A, nb[i], em[i], i > 3);
            chk({6'h00, fce, ev[2]}, ex[i]);
            chk({3'h0, emp}, {3'h0, em[i]});
        end
    endtask : t_runt
    // Freeze mid-packet, then reset: the held beat must clear and the
    // unfinished packet must be forgotten
    task t_hold;
        @(posedge ref_clk);
        upBeat <= '{1'b1, 1'b1, 1'b0, 1'b0, 6'h00, 5'h00, mk(16'h0001)};
        @(posedge ref_clk);
        upBeat.valid <= 1'b0;
        clkEn <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({6'h00, bv, fb}, 8'h03);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        #1;
        chk({bv, fb, lb, fcv, fce, kind}, 8'h00);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        clkEn <= 1'b1;
        @(posedge ref_clk);
        upBeat <= '{1'b1, 1'b0, 1'b1, 1'b1, 6'h00, 5'h00, 256'h5A};
        @(posedge ref_clk);
        upBeat.valid <= 1'b0;
        #1;
        chk({6'h00, bv, fcv}, 8'h00);
    endtask : t_hold
    initial begin
        repeat (3) @(posedge ref_clk);
        #1;
        chk({bv, fcv, fce, kind, ev[1:0]}, 8'h00);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        t_stray();
        t_kinds();
        t_runt();
        t_hold();
        end_sim();
    end
endmodule : rxfs_status_tb
`default_nettype wire
